// >>> verilog/tap_pkg.sv
// Constants and carrier types for the boundary scan test access port.
package tap_pkg;
  // -----------------------------------------------------------------
  // Instruction codes
  // -----------------------------------------------------------------
  localparam int IR_W = 4;
  localparam logic [3:0] INS_BYPASS = 4'h0;
  localparam logic [3:0] INS_SAMPLE = 4'h1;
  localparam logic [3:0] INS_IDENT = 4'h2;
  localparam logic [3:0] INS_USER = 4'h3;
  localparam logic [3:0] INS_CLAMP = 4'h4;
  localparam logic [3:0] INS_HIGHZ = 4'h5;
  localparam logic [3:0] INS_EXTEST = 4'h7;
  localparam logic [3:0] INS_IFSW = 4'h8;
  localparam logic [3:0] INS_REG_RD = 4'h9;
  localparam logic [3:0] INS_REG_WR = 4'hA;
  // -----------------------------------------------------------------
  // Register lengths and identity
  // -----------------------------------------------------------------
  localparam int BSR_W = 24;
  localparam int ID_W = 32;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int WR_W = ADDR_W + DATA_W;
  localparam int NPIN = 12;
  // Identity fields are arbitrary neutral values.
  localparam logic [3:0] ID_VERSION = 4'h6;
  localparam logic [15:0] ID_PART = 16'h1234;
  localparam logic [10:0] ID_MAKER = 11'h055;
  localparam logic [31:0] IDCODE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam int BSR_PIN2_OUT2 = 7;
  localparam int BSR_PIN3_IN = 6;
  localparam logic [2:0] RESET_HIGHS = 3'h5;

  typedef enum {
    S_RESET, S_IDLE, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PAUSE_DR,
    S_EX2_DR, S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR,
    S_PAUSE_IR, S_EX2_IR, S_UPD_IR
  } tap_state_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } scan_in_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic we;
  } reg_req_s;
endpackage

// >>> verilog/boundary_scan_tap.sv
// Boundary scan test access port with register access extensions.
//
// Operation
// (RULE1) Decode the ten instruction codes 0 to 10; code 6 is not decoded and acts as bypass.
// (RULE2) Data register length follows the instruction.
// (RULE3) Clock, mode, data in, data out pins.
// (RULE4) Stopped test clock keeps all state.
// (RULE5) Next state from mode sampled rising.
// (RULE6) Tester changes inputs on falling edge.
// (RULE7) Five mode-high clocks reset, load identification.
// (RULE8) Data in shifted on rising edge.
// (RULE9) Data out updates on falling edge.
// (RULE10) Data out driver off outside shift states.
// (RULE11) Bypass passes data, normal function undisturbed.
// (RULE12) Boundary cells own pins during test instructions.
// (RULE13) Twenty-four cells, control above each pin; cell 7 above input-only pin 3 holds PIN2_OUT2 instead of a control.
// (RULE14) Bidir cells, control cells, one input cell.
// (RULE15) Identification value with low bit one.
// (RULE16) User code from first four memory bytes.
// (RULE17) Interface switch bit applies at Update-DR.
// (RULE18) Read: capture address, shift, update address.
// (RULE19) Write: address and data written at Update-DR.
// (RULE20) Sixteen-state machine, bypass captures zero.
`timescale 1ns/1ps
module boundary_scan_tap
  import tap_pkg::*;
(
  input wire logic CLK, // System clock, 100 MHz.
  input wire logic RST, // Asynchronous reset, active high.
  input wire logic TCK, // Test clock pin.
  input wire logic TMS, // Test mode select pin.
  input wire logic TDI, // Test data in pin.
  output logic TDO, // Test data out.
  output logic TDO_OE, // Test data out driver enable.
  input wire logic [31:0] USER_CODE, // First four memory bytes.
  input wire logic [NPIN-1:0] CORE_OUT, // Core pin output values.
  input wire logic [NPIN-1:0] CORE_OE, // Core pin enables.
  input wire logic [NPIN-1:0] PAD_IN, // Pad input values.
  output logic [NPIN-1:0] PAD_OUT, // Pad output values.
  output logic [NPIN-1:0] PAD_OE, // Pad enables.
  output logic PIN2_OUT2, // Second output of host_port_pin_2.
  output logic HOST_IF_OFF, // Host/SAM interface disabled.
  output logic [ADDR_W-1:0] REG_ADDR, // Current register address.
  input wire logic [DATA_W-1:0] REG_RDATA, // Register read data.
  output logic [DATA_W-1:0] REG_WDATA, // Register write data.
  output logic REG_WE // One-cycle register write strobe.
);
  // -----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // -----------------------------------------------------------------
  scan_in_s sync1, sync2, prev, next_sync1;
  logic rise, fall;
  always_comb begin
    next_sync1 = '{tck: TCK, tms: TMS, tdi: TDI}; // RULE3
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync1 <= '{tck: 1'b1, tms: 1'b1, tdi: 1'b1};
      sync2 <= '{tck: 1'b1, tms: 1'b1, tdi: 1'b1};
      prev <= '{tck: 1'b1, tms: 1'b1, tdi: 1'b1};
    end else begin
      sync1 <= next_sync1;
      sync2 <= sync1;
      prev <= sync2;
    end
  end
  // State moves only on test clock edges, so a stopped clock holds all.
  assign rise = sync2.tck & ~prev.tck; // RULE4
  assign fall = ~sync2.tck & prev.tck; // RULE9

  // -----------------------------------------------------------------
  // Controller
  // -----------------------------------------------------------------
  tap_state_e state, next_state;
  always_comb begin
    next_state = state;
    if (rise) begin // RULE5
      case (state) // RULE20
        S_RESET: next_state = sync2.tms ? S_RESET : S_IDLE; // RULE7
        S_IDLE: next_state = sync2.tms ? S_SEL_DR : S_IDLE;
        S_SEL_DR: next_state = sync2.tms ? S_SEL_IR : S_CAP_DR;
        S_CAP_DR: next_state = sync2.tms ? S_EX1_DR : S_SH_DR;
        S_SH_DR: next_state = sync2.tms ? S_EX1_DR : S_SH_DR;
        S_EX1_DR: next_state = sync2.tms ? S_UPD_DR : S_PAUSE_DR;
        S_PAUSE_DR: next_state = sync2.tms ? S_EX2_DR : S_PAUSE_DR;
        S_EX2_DR: next_state = sync2.tms ? S_UPD_DR : S_SH_DR;
        S_UPD_DR: next_state = sync2.tms ? S_SEL_DR : S_IDLE;
        S_SEL_IR: next_state = sync2.tms ? S_RESET : S_CAP_IR;
        S_CAP_IR: next_state = sync2.tms ? S_EX1_IR : S_SH_IR;
        S_SH_IR: next_state = sync2.tms ? S_EX1_IR : S_SH_IR;
        S_EX1_IR: next_state = sync2.tms ? S_UPD_IR : S_PAUSE_IR;
        S_PAUSE_IR: next_state = sync2.tms ? S_EX2_IR : S_PAUSE_IR;
        S_EX2_IR: next_state = sync2.tms ? S_UPD_IR : S_SH_IR;
        S_UPD_IR: next_state = sync2.tms ? S_SEL_DR : S_IDLE;
        default: next_state = S_RESET;
      endcase
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= S_RESET;
    end else begin
      state <= next_state;
    end
  end

  // -----------------------------------------------------------------
  // Instruction and data chains
  // -----------------------------------------------------------------
  logic [IR_W-1:0] ir_sh, ir, next_ir_sh, next_ir;
  logic [ID_W-1:0] dr, next_dr;
  logic [BSR_W-1:0] bsr, next_bsr;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] wdata, next_wdata;
  logic if_off, next_if_off, we, next_we, tdo, next_tdo, oe, next_oe;
  logic serial;
  int unsigned dr_len;
  logic [BSR_W-1:0] cap_bsr;

  // Capture image: pins read back the pad, controls read the enables.
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin // RULE13
      cap_bsr[2*i] = PAD_IN[i];
      cap_bsr[2*i+1] = CORE_OE[i];
    end
    cap_bsr[BSR_PIN2_OUT2] = CORE_OUT[4]; // RULE13
    cap_bsr[BSR_PIN3_IN] = PAD_IN[3]; // RULE14
  end

  always_comb begin
    case (ir) // RULE2
      INS_SAMPLE, INS_EXTEST: dr_len = BSR_W;
      INS_IDENT, INS_USER: dr_len = ID_W;
      INS_IFSW: dr_len = 1;
      INS_REG_RD: dr_len = WR_W;
      INS_REG_WR: dr_len = WR_W;
      default: dr_len = 1;
    endcase
  end

  always_comb begin
    next_ir_sh = ir_sh;
    next_ir = ir;
    next_dr = dr;
    next_bsr = bsr;
    next_addr = addr;
    next_wdata = wdata;
    next_if_off = if_off;
    next_we = 1'b0;
    next_tdo = tdo;
    next_oe = oe;
    if (rise) begin
      case (state)
        S_CAP_IR: next_ir_sh = IR_CAPTURE;
        S_SH_IR: next_ir_sh = {sync2.tdi, ir_sh[IR_W-1:1]}; // RULE8
        S_UPD_IR: next_ir = ir_sh; // RULE1
        S_CAP_DR: begin
          case (ir) // RULE1
            INS_IDENT: next_dr = IDCODE; // RULE15
            INS_USER: next_dr = USER_CODE; // RULE16
            INS_SAMPLE, INS_EXTEST: next_bsr = cap_bsr;
            INS_REG_RD: begin
              // Address in low bits, read data above for shifting out.
              next_dr = {17'h0_0000, REG_RDATA, addr}; // RULE18
            end
            default: next_dr = 32'h0000_0000; // RULE20
          endcase
        end
        S_SH_DR: begin
          if (ir == INS_SAMPLE || ir == INS_EXTEST) begin
            next_bsr = {sync2.tdi, bsr[BSR_W-1:1]}; // RULE8
          end else begin
            next_dr = dr >> 1;
            next_dr[dr_len-1] = sync2.tdi; // RULE11
          end
        end
        S_UPD_DR: begin
          case (ir)
            INS_IFSW: next_if_off = dr[0]; // RULE17
            INS_REG_RD: next_addr = dr[ADDR_W-1:0]; // RULE18
            INS_REG_WR: begin
              if (if_off) begin // RULE19
                next_addr = dr[ADDR_W-1:0];
                next_wdata = dr[WR_W-1 -: DATA_W];
                next_we = 1'b1;
              end
            end
            default: ;
          endcase
        end
        default: ;
      endcase
      // Load on entry, so the identification code is already in place
      // in the first cycle of Test-Logic-Reset.
      if (next_state == S_RESET) begin
        next_ir = INS_IDENT; // RULE7
        next_if_off = 1'b0;
      end
    end
    if (fall) begin // RULE9
      next_oe = (state == S_SH_DR) || (state == S_SH_IR); // RULE10
      if (state == S_SH_IR) begin
        next_tdo = ir_sh[0];
      end else if (state == S_SH_DR) begin
        next_tdo = serial;
      end
    end
  end

  // Short chains shift in at the top bit of their length, so the
  // serial output is always bit 0 whatever the length.
  always_comb begin
    if (ir == INS_SAMPLE || ir == INS_EXTEST) begin
      serial = bsr[0];
    end else begin
      serial = dr[0];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ir_sh <= IR_CAPTURE;
      ir <= INS_IDENT;
      dr <= '0;
      bsr <= '0;
      addr <= ADDR_RESET;
      wdata <= '0;
      if_off <= 1'b0;
      we <= 1'b0;
      tdo <= 1'b1;
      oe <= 1'b0;
    end else begin
      ir_sh <= next_ir_sh;
      ir <= next_ir;
      dr <= next_dr;
      bsr <= next_bsr;
      addr <= next_addr;
      wdata <= next_wdata;
      if_off <= next_if_off;
      we <= next_we;
      tdo <= next_tdo;
      oe <= next_oe;
    end
  end

  // -----------------------------------------------------------------
  // Pin control
  // -----------------------------------------------------------------
  logic test_mode;
  assign test_mode = ir == INS_EXTEST || ir == INS_CLAMP ||
    ir == INS_HIGHZ; // RULE12
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (ir == INS_HIGHZ) begin
        PAD_OUT[i] = 1'b0;
        PAD_OE[i] = 1'b0;
      end else if (test_mode) begin // RULE12
        PAD_OUT[i] = bsr[2*i];
        PAD_OE[i] = bsr[2*i+1];
      end else begin
        PAD_OUT[i] = CORE_OUT[i];
        PAD_OE[i] = CORE_OE[i]; // RULE11
      end
    end
    // The input cell only observes its pin and never drives it.
    PAD_OUT[3] = test_mode ? 1'b0 : CORE_OUT[3]; // RULE14
    PAD_OE[3] = test_mode ? 1'b0 : CORE_OE[3];
  end
  assign PIN2_OUT2 = test_mode ? bsr[BSR_PIN2_OUT2] : CORE_OUT[4];
  assign TDO = tdo;
  assign TDO_OE = oe;
  assign HOST_IF_OFF = if_off;
  assign REG_ADDR = addr;
  assign REG_WDATA = wdata;
  assign REG_WE = we;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  // Mode-high rising edges in a row, held once they reach five.
  logic [2:0] tms_run, next_tms_run;
  always_comb begin
    next_tms_run = tms_run;
    if (rise && !sync2.tms) begin
      next_tms_run = 3'h0;
    end else if (rise && tms_run != RESET_HIGHS) begin
      next_tms_run = tms_run + 3'h1;
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tms_run <= 3'h0;
    end else begin
      tms_run <= next_tms_run;
    end
  end
  sequence wr_update;
    rise && state == S_UPD_DR && ir == INS_REG_WR && if_off;
  endsequence
  AST_TLR_FIVE: assert property (@(posedge CLK) disable iff (RST) // RULE7
    tms_run == RESET_HIGHS |-> state == S_RESET)
    else $error("five mode-high clocks did not reach reset");
  AST_TLR_IR: assert property (@(posedge CLK) disable iff (RST) // RULE7
    state == S_RESET |=> ir == INS_IDENT)
    else $error("identification not loaded in reset state");
  AST_OE_SHIFT: assert property (@(posedge CLK) disable iff (RST) // RULE10
    $past(fall) |-> oe == $past(state == S_SH_DR || state == S_SH_IR))
    else $error("data out driver not following the shift state");
  AST_WE_FIRE: assert property (@(posedge CLK) disable iff (RST) // RULE19
    wr_update |=> we)
    else $error("enabled register write gave no strobe");
  AST_TDO_FALL: assert property (@(posedge CLK) disable iff (RST) // RULE9
    !$past(fall) |-> $stable(tdo))
    else $error("data out changed without falling edge");
  AST_HOLD: assert property (@(posedge CLK) disable iff (RST) // RULE4
    !rise |=> $stable(state) && $stable(ir))
    else $error("state changed without rising edge");
  AST_WE_GUARD: assert property (@(posedge CLK) disable iff (RST) // RULE19
    we |-> $past(if_off) && $past(state == S_UPD_DR))
    else $error("write strobe without enabled access");
  AST_WE_PULSE: assert property (@(posedge CLK) disable iff (RST) // RULE19
    we |=> !we)
    else $error("write strobe longer than one cycle");
  AST_IFSW: assert property (@(posedge CLK) disable iff (RST) // RULE17
    $changed(if_off) && state != S_RESET |->
      $past(state == S_UPD_DR && ir == INS_IFSW))
    else $error("interface switch changed outside update");
  AST_ADDR: assert property (@(posedge CLK) disable iff (RST) // RULE18
    $changed(addr) |-> $past(state == S_UPD_DR))
    else $error("address changed outside update");
  AST_IR_UPD: assert property (@(posedge CLK) disable iff (RST) // RULE1
    $changed(ir) |-> $past(state == S_UPD_IR) || state == S_RESET)
    else $error("instruction changed outside update");
  AST_HIGHZ: assert property (@(posedge CLK) disable iff (RST) // RULE12
    ir == INS_HIGHZ |-> PAD_OE == '0)
    else $error("pads driven under high impedance");
endmodule

// >>> sim/scan_tester.sv
// Model of the external boundary scan controller that drives the port.
`timescale 1ns/1ps
module scan_tester (
  input wire logic CLK, // System clock, paces the test clock.
  output logic TCK, // Test clock, still outside frames.
  output logic TMS, // Test mode select.
  output logic TDI, // Test data to the device.
  input wire logic TDO, // Test data from the device.
  input wire logic TDO_OE // Device drives the data output.
);
  // Pull-up levels while idle; the test clock rests low between frames.
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b1;
  end

  // A released data line floats; show the inverse so a stale read fails.
  logic tdo_line;
  assign tdo_line = TDO_OE ? TDO : ~TDO;

  // ---------------------------------------------------------------
  // One test clock period of 16 system clocks
  // ---------------------------------------------------------------
  // Inputs change at the falling test clock edge, sampled at the rise.
  task automatic tick(input logic ms, input logic di, output logic d,
                      output logic oe);
    TMS <= ms;
    TDI <= di;
    repeat (8) @(posedge CLK);
    TCK <= 1'b1;
    d = tdo_line;
    oe = TDO_OE;
    repeat (8) @(posedge CLK);
    TCK <= 1'b0;
  endtask

  // Five high mode cycles reach reset, one low cycle reaches idle.
  task automatic reset5();
    logic d;
    logic o;
    repeat (5) tick(1'b1, 1'b1, d, o);
    tick(1'b0, 1'b1, d, o);
  endtask

  // ---------------------------------------------------------------
  // Instruction or data scan from idle back to idle
  // ---------------------------------------------------------------
  task automatic shift(input logic ir, input logic [31:0] din,
                       input int n, output logic [31:0] dout,
                       output logic oe_ok);
    logic d;
    logic o;
    dout = '0;
    oe_ok = 1'b1;
    tick(1'b1, 1'b1, d, o);
    if (ir) begin
      tick(1'b1, 1'b1, d, o);
    end
    tick(1'b0, 1'b1, d, o);
    tick(1'b0, 1'b1, d, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], d, o);
      dout[i] = d;
      if (o !== 1'b1) begin
        oe_ok = 1'b0;
      end
    end
    tick(1'b1, 1'b1, d, o);
    tick(1'b0, 1'b1, d, o);
    repeat (8) @(posedge CLK);
    if (TDO_OE !== 1'b0) begin
      oe_ok = 1'b0;
    end
  endtask
endmodule

// >>> sim/tb_top.sv
// Self-checking testbench for the boundary scan test access port.
`timescale 1ns/1ps
module tb_top
  import tap_pkg::*;
;
  logic clk, rst, tck, tms, tdi, tdo, tdo_oe, pin2_out2, host_if_off;
  logic reg_we;
  logic [31:0] user_code;
  logic [NPIN-1:0] core_out, core_oe, pad_in, pad_out, pad_oe;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_rdata, reg_wdata;
  logic [31:0] dout;
  logic ok;
  int num_errors = 0;
  int num_checks = 0;
  int we_cnt = 0;

  boundary_scan_tap uut (.CLK(clk), .RST(rst), .TCK(tck), .TMS(tms),
    .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .USER_CODE(user_code),
    .CORE_OUT(core_out), .CORE_OE(core_oe), .PAD_IN(pad_in),
    .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PIN2_OUT2(pin2_out2),
    .HOST_IF_OFF(host_if_off), .REG_ADDR(reg_addr),
    .REG_RDATA(reg_rdata), .REG_WDATA(reg_wdata), .REG_WE(reg_we));
  scan_tester tester (.CLK(clk), .TCK(tck), .TMS(tms), .TDI(tdi),
    .TDO(tdo), .TDO_OE(tdo_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (reg_we === 1'b1) begin
      we_cnt <= we_cnt + 1;
    end
  end

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ir(input logic [3:0] code);
    tester.shift(1'b1, {28'h000_0, code}, IR_W, dout, ok);
    chk(dout[3:0], IR_CAPTURE);
    chk(ok, 1'b1);
  endtask

  task automatic dr(input logic [31:0] din, input int n);
    tester.shift(1'b0, din, n, dout, ok);
    chk(ok, 1'b1);
  endtask

  task automatic print_verdict();
    $display("Compares %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_ident();
    tester.reset5();
    dr(32'h0000_0000, ID_W);
    chk(dout, IDCODE);
    chk(dout[0], 1'b1);
    ir(INS_BYPASS);
    tester.reset5();
    dr(32'h0000_0000, ID_W);
    chk(dout, IDCODE);
    $display("Test ident done");
  endtask

  task automatic t_bypass();
    ir(INS_BYPASS);
    dr(32'h0000_00A5, 8);
    chk(dout[7:0], 8'h4A);
    chk(pad_out, core_out);
    chk(pad_oe, core_oe);
    $display("Test bypass done");
  endtask

  // The test clock rests for 300 cycles between instruction and data.
  task automatic t_user();
    ir(INS_USER);
    repeat (300) @(posedge clk);
    dr(32'h0000_0000, ID_W);
    chk(dout, user_code);
    $display("Test user code done");
  endtask

  // Cell 6 belongs to the input-only pin and cell 7 to PIN2_OUT2, so index 3 is masked.
  task automatic t_boundary();
    logic [23:0] p;
    logic [NPIN-1:0] eo, ee;
    p = 24'hC3_5A96;
    for (int i = 0; i < NPIN; i++) begin
      eo[i] = p[2*i];
      ee[i] = p[2*i+1];
    end
    ir(INS_SAMPLE);
    dr({8'h00, p}, BSR_W);
    for (int i = 0; i < NPIN; i++) begin
      chk(dout[2*i], pad_in[i]);
      if (i != 3) begin
        chk(dout[2*i+1], core_oe[i]);
      end
    end
    chk(dout[BSR_PIN2_OUT2], core_out[4]);
    ir(INS_EXTEST);
    chk(pad_out & 12'hFF7, eo & 12'hFF7);
    chk(pad_oe & 12'hFF7, ee & 12'hFF7);
    chk(pin2_out2, p[BSR_PIN2_OUT2]);
    ir(INS_HIGHZ);
    chk(pad_oe & 12'hFF7, 12'h000);
    ir(INS_CLAMP);
    chk(pad_out & 12'hFF7, eo & 12'hFF7);
    ir(INS_BYPASS);
    chk(pad_out, core_out);
    $display("Test boundary done");
  endtask

  task automatic t_regacc();
    chk(host_if_off, 1'b0);
    ir(INS_REG_WR);
    dr({17'h0, 8'h3C, 7'h55}, WR_W);
    chk(we_cnt, 0);
    ir(INS_IFSW);
    dr(32'h0000_0001, 1);
    chk(host_if_off, 1'b1);
    ir(INS_REG_WR);
    dr({17'h0, 8'hC3, 7'h2A}, WR_W);
    chk(we_cnt, 1);
    chk(reg_wdata, 8'hC3);
    chk(reg_addr, 7'h2A);
    ir(INS_REG_RD);
    dr(32'h0000_0011, WR_W);
    chk(dout[6:0], 7'h2A);
    chk(dout[14:7], 8'h96);
    chk(reg_addr, 7'h11);
    ir(INS_IFSW);
    dr(32'h0000_0000, 1);
    chk(host_if_off, 1'b0);
    $display("Test register access done");
  endtask

  initial begin
    rst = 1'b1;
    user_code = 32'h0000_0000;
    core_out = 12'h000;
    core_oe = 12'h000;
    pad_in = 12'h000;
    reg_rdata = 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    user_code <= 32'h1357_9BDF;
    core_out <= 12'h6C9;
    core_oe <= 12'h3A5;
    pad_in <= 12'hA5C;
    reg_rdata <= 8'h96;
    repeat (5) @(posedge clk);
    t_ident();
    t_bypass();
    t_user();
    t_boundary();
    t_regacc();
    print_verdict();
  end

  // The scenarios need about 6400 cycles; this limit leaves margin.
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule
